// File: smbcsr_mst.sv
// smbcsr_mst: behavioural link master issuing byte-layer pulses.
// assumes the byte layer answers one lk_clk after each request.
`default_nettype none

module smbcsr_mst (
  input  wire logic       lk_clk,
  input  wire logic       lk_rx_ack,
  input  wire logic       lk_tx_valid,
  input  wire logic [7:0] lk_tx_byte,
  output var  logic       lk_start = 1'b0,
  output var  logic [7:0] lk_addr_byte = 8'h00,
  output var  logic       lk_rx_valid = 1'b0,
  output var  logic [7:0] lk_rx_byte = 8'h00,
  output var  logic       lk_stop = 1'b0,
  output var  logic       lk_tx_req = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // running checksum and pulse tasks
  // ---------------------------------------------------------------
  logic [7:0] crc = 8'h00;

  function automatic logic [7:0] crc_step(input logic [7:0] c,
                                          input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++)
      r = r[7] ? ((r << 1) ^ 8'h07) : (r << 1);
    return r;
  endfunction : crc_step

  task automatic put_start(input logic [7:0] a);
    @(negedge lk_clk);
    lk_start = 1'b1;
    lk_addr_byte = a;
    crc = crc_step(8'h00, a);
    @(negedge lk_clk);
    lk_start = 1'b0;
    lk_addr_byte = ~a;
  endtask : put_start

  // released lines show the inverse, never a stale copy
  task automatic put_byte(input logic [7:0] b, output logic ack);
    @(negedge lk_clk);
    lk_rx_valid = 1'b1;
    lk_rx_byte = b;
    crc = crc_step(crc, b);
    @(negedge lk_clk);
    lk_rx_valid = 1'b0;
    lk_rx_byte = ~b;
    ack = lk_rx_ack;
  endtask : put_byte

  task automatic put_stop;
    @(negedge lk_clk);
    lk_stop = 1'b1;
    @(negedge lk_clk);
    lk_stop = 1'b0;
  endtask : put_stop

  task automatic get_byte(output logic [8:0] vb);
    @(negedge lk_clk);
    lk_tx_req = 1'b1;
    @(negedge lk_clk);
    lk_tx_req = 1'b0;
    vb = {lk_tx_valid, lk_tx_byte};
  endtask : get_byte
endmodule : smbcsr_mst

`default_nettype wire

// File: smbcsr_pkg.sv
// smbcsr_pkg: constants, packet type and checksum helper of the
// slave SMBus register-access command layer.
// assumes the byte layer below it delivers whole bytes and returns the ack or nack given here.
`default_nettype none

package smbcsr_pkg;

  // ---------------------------------------------------------------
  // command code layout
  // ---------------------------------------------------------------
  localparam int CC_END_BIT   = 0;
  localparam int CC_START_BIT = 1;
  localparam int CC_FUNC_LSB  = 2;
  localparam int CC_SIZE_LSB  = 5;
  localparam int CC_PEC_BIT   = 7;

  localparam logic [2:0] FUNC_CSR   = 3'h0;
  localparam logic [1:0] SIZE_BYTE  = 2'h0;
  localparam logic [1:0] SIZE_WORD  = 2'h1;
  localparam logic [1:0] SIZE_BLOCK = 2'h2;
  localparam logic [1:0] SIZE_RSVD  = 2'h3;

  // ---------------------------------------------------------------
  // command byte layout
  // ---------------------------------------------------------------
  localparam int CMD_LANE_LSB = 0;
  localparam int CMD_OP_BIT   = 4;
  localparam int CMD_READ_UNCLAIMED_FLAG_BIT = 6;
  localparam int CMD_WRITE_UNCLAIMED_FLAG_BIT = 7;

  // ---------------------------------------------------------------
  // sequence lengths, counts and reset values
  // ---------------------------------------------------------------
  localparam logic [2:0] FIELD_COUNT  = 3'h7;
  localparam logic [2:0] SETUP_FIELDS = 3'h3;
  localparam logic [7:0] REPLY_COUNT  = 8'h07;
  localparam logic [7:0] HDR_BLOCK    = 8'h02;
  localparam logic [7:0] HDR_SHORT    = 8'h01;
  localparam logic [7:0] LEN_BYTE     = 8'h01;
  localparam logic [7:0] LEN_WORD     = 8'h02;
  localparam logic [7:0] IDLE_BYTE    = 8'hFF;
  localparam logic [7:0] CRC_INIT     = 8'h00;
  localparam logic [7:0] CRC_POLY     = 8'h07;
  localparam logic       FLAG_RST     = 1'b0;

  // one register access, both directions
  typedef struct packed {
    logic [7:0]  cmd;
    logic [13:0] index;
    logic [31:0] data;
  } smbcsr_pkt_t;

  localparam smbcsr_pkt_t PKT_RST = '0;

  // checksum over one byte, x^8+x^2+x+1
  function automatic logic [7:0] smbcsr_crc8(input logic [7:0] crc,
                                             input logic [7:0] b);
    logic [7:0] c;
    c = crc ^ b;
    for (int i = 0; i < 8; i++)
    begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : smbcsr_crc8

endpackage : smbcsr_pkg

`default_nettype wire

// File: smbcsr_sync.sv
// smbcsr_sync: two-flop synchroniser for levels and toggles.
// assumes each bit changes alone or is held stable by a handshake.
`default_nettype none

module smbcsr_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // no reset: a reset flop here would itself need synchronising
  always_ff @(posedge clk)
  begin
    meta_reg <= d;
    q        <= meta_reg;
  end

endmodule : smbcsr_sync

`default_nettype wire

// File: smbcsr_top.sv
// smbcsr_top: parses slave SMBus register-access commands on the link
// clock and performs the register access on the system clock.
// assumes a byte layer on lk_clk and a register port on clock.
`default_nettype none

module smbcsr_top (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        lk_clk,
  input  wire logic        lk_start,
  input  wire logic [7:0]  lk_addr_byte,
  input  wire logic        lk_rx_valid,
  input  wire logic [7:0]  lk_rx_byte,
  input  wire logic        lk_stop,
  input  wire logic        lk_tx_req,
  output var  logic        lk_rx_ack,
  output var  logic        lk_tx_valid,
  output var  logic [7:0]  lk_tx_byte,
  output var  logic        lk_busy,
  output var  logic        csr_valid,
  output var  logic        csr_write,
  output var  logic [13:0] csr_index,
  output var  logic [3:0]  csr_be,
  output var  logic [31:0] csr_wdata,
  input  wire logic        csr_ready,
  input  wire logic        csr_claimed,
  input  wire logic [31:0] csr_rdata,
  output var  logic        read_unclaimed_flag,
  output var  logic        write_unclaimed_flag
);
  import smbcsr_pkg::*;

  // ---------------------------------------------------------------
  // crossings
  // ---------------------------------------------------------------
  logic lk_rst;
  logic req_tog_reg;
  logic ack_tog_reg;
  logic req_sync;
  logic ack_sync;

  smbcsr_sync #(.W(1)) u_rst_sync (
    .clk (lk_clk),
    .d   (sys_rst),
    .q   (lk_rst)
  );

  smbcsr_sync #(.W(1)) u_req_sync (
    .clk (clock),
    .d   (req_tog_reg),
    .q   (req_sync)
  );

  smbcsr_sync #(.W(1)) u_ack_sync (
    .clk (lk_clk),
    .d   (ack_tog_reg),
    .q   (ack_sync)
  );

  // ---------------------------------------------------------------
  // link side: transaction decode
  // ---------------------------------------------------------------
  logic [7:0]  command_code_byte_reg;
  logic [7:0]  cnt_reg;
  logic [7:0]  pos_reg;
  logic [7:0]  tx_pos_reg;
  logic [7:0]  crc_reg;
  logic        pec_ok_reg;
  logic        dir_rd_reg;
  logic [2:0]  fld_ptr_reg;
  logic [2:0]  rd_ptr_reg;
  logic [7:0]  fld_reg [0:6];
  logic        ack_seen_reg;
  smbcsr_pkt_t pkt_lk_reg;
  smbcsr_pkt_t res_lk_reg;
  smbcsr_pkt_t res_reg;

  wire [2:0] cc_func  = command_code_byte_reg[CC_FUNC_LSB +: 3];
  wire [1:0] cc_size  = command_code_byte_reg[CC_SIZE_LSB +: 2];
  wire       cc_block = (cc_size == SIZE_BLOCK);
  wire       cc_pec   = command_code_byte_reg[CC_PEC_BIT];
  wire [7:0] hdr_len  = cc_block ? HDR_BLOCK : HDR_SHORT;
  wire [7:0] short_len = (cc_size == SIZE_WORD) ? LEN_WORD : LEN_BYTE;
  // in block size the write length comes from the master's count, which excludes the checksum
  wire [7:0] rx_len   = cc_block ? cnt_reg : short_len;
  wire [7:0] rx_off   = pos_reg - hdr_len;
  wire       rx_data  = (pos_reg >= hdr_len) && (rx_off < rx_len);
  wire [8:0] pec_pos  = {1'b0, hdr_len} + {1'b0, rx_len};
  wire       rx_pec   = cc_pec && ({1'b0, pos_reg} == pec_pos);
  wire       ack_edge = (ack_sync != ack_seen_reg);
  wire       rx_take  = lk_rx_valid && !lk_busy;
  wire       is_rd_op = fld_reg[0][CMD_OP_BIT];

  wire launch_ok = !lk_busy && !dir_rd_reg && (pos_reg != 8'h00)
                 && (cc_func == FUNC_CSR)
                 && (cc_size != SIZE_RSVD)
                 && command_code_byte_reg[CC_END_BIT]
                 && (!cc_pec || pec_ok_reg)
                 && (is_rd_op ? (fld_ptr_reg >= SETUP_FIELDS)
                              : (fld_ptr_reg == FIELD_COUNT));

  // reply bytes in wire order: status command, index, data
  wire [7:0] res_bytes [0:6];
  assign res_bytes[0] = res_lk_reg.cmd;
  assign res_bytes[1] = res_lk_reg.index[7:0];
  assign res_bytes[2] = {2'b00, res_lk_reg.index[13:8]};
  assign res_bytes[3] = res_lk_reg.data[7:0];
  assign res_bytes[4] = res_lk_reg.data[15:8];
  assign res_bytes[5] = res_lk_reg.data[23:16];
  assign res_bytes[6] = res_lk_reg.data[31:24];

  wire [7:0] tx_hdr  = cc_block ? 8'h01 : 8'h00;
  wire [7:0] tx_len  = cc_block ? REPLY_COUNT : short_len;
  wire [7:0] tx_off  = tx_pos_reg - tx_hdr;
  wire       tx_data = (tx_pos_reg >= tx_hdr) && (tx_off < tx_len);
  wire [7:0] tx_seq  = (rd_ptr_reg < FIELD_COUNT)
                     ? res_bytes[rd_ptr_reg] : IDLE_BYTE;
  // count byte first in block size, checksum after the counted bytes
  wire [7:0] tx_src  = lk_busy ? IDLE_BYTE
                     : (cc_block && tx_pos_reg == 8'h00) ? REPLY_COUNT
                     : tx_data ? tx_seq : crc_reg;

  // ---------------------------------------------------------------
  // link side: position, checksum and direction
  // ---------------------------------------------------------------
  always_ff @(posedge lk_clk)
  begin
    if (lk_rst)
    begin
      pos_reg    <= 8'h00;
      tx_pos_reg <= 8'h00;
      crc_reg    <= CRC_INIT;
      dir_rd_reg <= 1'b0;
    end
    else if (lk_start)
    begin
      dir_rd_reg <= lk_addr_byte[0];
      tx_pos_reg <= 8'h00;
      // a repeated start for the read half keeps the running checksum
      crc_reg    <= smbcsr_crc8(lk_addr_byte[0] ? crc_reg : CRC_INIT,
                                lk_addr_byte);
      if (!lk_addr_byte[0])
        pos_reg <= 8'h00;
    end
    else if (rx_take)
    begin
      crc_reg <= smbcsr_crc8(crc_reg, lk_rx_byte);
      if (pos_reg != 8'hFF)
        pos_reg <= pos_reg + 8'h01;
    end
    else if (lk_tx_req)
    begin
      crc_reg <= smbcsr_crc8(crc_reg, tx_src);
      if (tx_pos_reg != 8'hFF)
        tx_pos_reg <= tx_pos_reg + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // link side: field capture
  // ---------------------------------------------------------------
  always_ff @(posedge lk_clk)
  begin
    if (lk_rst)
    begin
      command_code_byte_reg   <= 8'h00;
      cnt_reg     <= 8'h00;
      pec_ok_reg  <= 1'b0;
      fld_ptr_reg <= 3'h0;
      for (int i = 0; i < 7; i++)
        fld_reg[i] <= 8'h00;
    end
    else if (rx_take)
    begin
      if (pos_reg == 8'h00)
      begin
        command_code_byte_reg  <= lk_rx_byte;
        pec_ok_reg <= !lk_rx_byte[CC_PEC_BIT];
        if (lk_rx_byte[CC_START_BIT])
          fld_ptr_reg <= 3'h0;
      end
      else if (pos_reg == 8'h01 && cc_block)
        cnt_reg <= lk_rx_byte;
      else if (rx_data && fld_ptr_reg < FIELD_COUNT)
      begin
        fld_reg[fld_ptr_reg] <= lk_rx_byte;
        fld_ptr_reg          <= fld_ptr_reg + 3'h1;
      end
      else if (rx_pec)
        pec_ok_reg <= (lk_rx_byte == crc_reg);
    end
  end

  // ---------------------------------------------------------------
  // link side: answers to the byte layer
  // ---------------------------------------------------------------
  always_ff @(posedge lk_clk)
  begin
    if (lk_rst)
    begin
      lk_rx_ack   <= 1'b0;
      lk_tx_valid <= 1'b0;
      lk_tx_byte  <= IDLE_BYTE;
      rd_ptr_reg  <= 3'h0;
    end
    else
    begin
      lk_rx_ack   <= rx_take;
      lk_tx_valid <= lk_tx_req && !lk_start && !lk_rx_valid;
      if (lk_tx_req && !lk_start && !lk_rx_valid)
        lk_tx_byte <= tx_src;
      if (rx_take && pos_reg == 8'h00 && lk_rx_byte[CC_START_BIT])
        rd_ptr_reg <= 3'h0;
      else if (lk_tx_req && !lk_start && !lk_rx_valid && tx_data
               && !lk_busy && rd_ptr_reg < FIELD_COUNT)
        rd_ptr_reg <= rd_ptr_reg + 3'h1;
    end
  end

  // ---------------------------------------------------------------
  // link side: hand-off to the system clock
  // ---------------------------------------------------------------
  always_ff @(posedge lk_clk)
  begin
    if (lk_rst)
    begin
      req_tog_reg  <= 1'b0;
      ack_seen_reg <= 1'b0;
      lk_busy      <= 1'b0;
      pkt_lk_reg   <= PKT_RST;
      res_lk_reg   <= PKT_RST;
    end
    else
    begin
      if (ack_edge)
      begin
        ack_seen_reg <= ack_sync;
        res_lk_reg   <= res_reg;
        lk_busy      <= 1'b0;
      end
      else if (lk_stop && !lk_start && !lk_rx_valid && launch_ok)
      begin
        pkt_lk_reg.cmd   <= fld_reg[0];
        pkt_lk_reg.index <= {fld_reg[2][5:0], fld_reg[1]};
        pkt_lk_reg.data  <= {fld_reg[6], fld_reg[5],
                             fld_reg[4], fld_reg[3]};
        req_tog_reg      <= ~req_tog_reg;
        lk_busy          <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // system side: register access
  // ---------------------------------------------------------------
  typedef enum logic { SMBCSR_IDLE, SMBCSR_ISSUE } smbcsr_state_t;

  smbcsr_state_t state_reg;
  smbcsr_pkt_t   pkt_reg;
  logic          req_seen_reg;

  wire req_edge = (req_sync != req_seen_reg);
  wire c_rd     = pkt_reg.cmd[CMD_OP_BIT];
  // a fresh result wins over a clear carried in the same command
  wire rflag_next = c_rd ? !csr_claimed
                  : (pkt_reg.cmd[CMD_READ_UNCLAIMED_FLAG_BIT] ? 1'b0
                                               : read_unclaimed_flag);
  wire wflag_next = !c_rd ? !csr_claimed
                  : (pkt_reg.cmd[CMD_WRITE_UNCLAIMED_FLAG_BIT] ? 1'b0
                                               : write_unclaimed_flag);

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state_reg            <= SMBCSR_IDLE;
      req_seen_reg         <= 1'b0;
      ack_tog_reg          <= 1'b0;
      pkt_reg              <= PKT_RST;
      res_reg              <= PKT_RST;
      csr_valid            <= 1'b0;
      csr_write            <= 1'b0;
      csr_index            <= 14'h0000;
      csr_be               <= 4'h0;
      csr_wdata            <= 32'h0000_0000;
      read_unclaimed_flag  <= FLAG_RST;
      write_unclaimed_flag <= FLAG_RST;
    end
    else
    begin
      case (state_reg)
        SMBCSR_IDLE:
        begin
          if (req_edge)
          begin
            req_seen_reg <= req_sync;
            pkt_reg      <= pkt_lk_reg;
            csr_valid    <= 1'b1;
            csr_write    <= !pkt_lk_reg.cmd[CMD_OP_BIT];
            csr_index    <= pkt_lk_reg.index;
            // lanes off stay untouched at the register
            csr_be       <= pkt_lk_reg.cmd[CMD_LANE_LSB +: 4];
            csr_wdata    <= pkt_lk_reg.data;
            state_reg    <= SMBCSR_ISSUE;
          end
        end
        SMBCSR_ISSUE:
        begin
          if (csr_ready)
          begin
            csr_valid            <= 1'b0;
            // claimed is all the flags report, not success
            read_unclaimed_flag  <= rflag_next;
            write_unclaimed_flag <= wflag_next;
            res_reg.cmd   <= {wflag_next, rflag_next, 1'b0,
                              pkt_reg.cmd[4:0]};
            res_reg.index <= pkt_reg.index;
            res_reg.data  <= c_rd ? csr_rdata : pkt_reg.data;
            ack_tog_reg   <= ~ack_tog_reg;
            state_reg     <= SMBCSR_IDLE;
          end
        end
        default:
        begin
          state_reg <= SMBCSR_IDLE;
        end
      endcase
    end
  end

endmodule : smbcsr_top

`default_nettype wire

// File: smbcsr_top_chk.sv
// smbcsr_top_chk: port-level assertions for the register-access layer.
// assumes it is bound to smbcsr_top and sees only its ports.
`default_nettype none

module smbcsr_top_chk (
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic        lk_clk,
  input wire logic        lk_start,
  input wire logic [7:0]  lk_addr_byte,
  input wire logic        lk_rx_valid,
  input wire logic [7:0]  lk_rx_byte,
  input wire logic        lk_stop,
  input wire logic        lk_tx_req,
  input wire logic        lk_rx_ack,
  input wire logic        lk_tx_valid,
  input wire logic [7:0]  lk_tx_byte,
  input wire logic        lk_busy,
  input wire logic        csr_valid,
  input wire logic        csr_write,
  input wire logic [13:0] csr_index,
  input wire logic [3:0]  csr_be,
  input wire logic [31:0] csr_wdata,
  input wire logic        csr_ready,
  input wire logic        csr_claimed,
  input wire logic [31:0] csr_rdata,
  input wire logic        read_unclaimed_flag,
  input wire logic        write_unclaimed_flag
);
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // link side, then register side
  // ---------------------------------------------------------------
  sequence s_take;
    lk_rx_valid && !lk_start;
  endsequence
  sequence s_done;
    csr_valid && csr_ready;
  endsequence

  a_ack_taken: assert property (
    @(posedge lk_clk) disable iff (sys_rst)
    s_take ##0 !lk_busy |=> lk_rx_ack) else $error("byte not acked");
  a_busy_nack: assert property (
    @(posedge lk_clk) disable iff (sys_rst)
    s_take ##0 lk_busy |=> !lk_rx_ack) else $error("busy byte acked");
  a_tx_answer: assert property (
    @(posedge lk_clk) disable iff (sys_rst)
    lk_tx_req && !lk_start && !lk_rx_valid |=> lk_tx_valid)
    else $error("read byte missing");
  a_tx_busy_ff: assert property (
    @(posedge lk_clk) disable iff (sys_rst)
    lk_tx_req && lk_busy && !lk_start && !lk_rx_valid
    |=> lk_tx_byte == 8'hFF) else $error("busy read not idle byte");
  a_req_hold: assert property (
    @(posedge clock) disable iff (sys_rst)
    csr_valid && !csr_ready |=> csr_valid
    && $stable({csr_write, csr_index, csr_be, csr_wdata}))
    else $error("request changed before ready");
  a_req_end: assert property (
    @(posedge clock) disable iff (sys_rst)
    s_done |=> !csr_valid) else $error("request not ended");
  a_wflag_set: assert property (
    @(posedge clock) disable iff (sys_rst)
    s_done ##0 (csr_write && !csr_claimed) |=> write_unclaimed_flag)
    else $error("write flag not set");
  a_wflag_clr: assert property (
    @(posedge clock) disable iff (sys_rst)
    s_done ##0 (csr_write && csr_claimed) |=> !write_unclaimed_flag)
    else $error("write flag not clear");
  a_rflag_set: assert property (
    @(posedge clock) disable iff (sys_rst)
    s_done ##0 (!csr_write && !csr_claimed) |=> read_unclaimed_flag)
    else $error("read flag not set");
  a_rflag_clr: assert property (
    @(posedge clock) disable iff (sys_rst)
    s_done ##0 (!csr_write && csr_claimed) |=> !read_unclaimed_flag)
    else $error("read flag not clear");
  a_flag_hold: assert property (
    @(posedge clock) disable iff (sys_rst)
    !(csr_valid && csr_ready) |=> $stable(read_unclaimed_flag)
    && $stable(write_unclaimed_flag)) else $error("flag moved alone");
endmodule : smbcsr_top_chk

bind smbcsr_top smbcsr_top_chk u_chk (.clock, .sys_rst, .lk_clk,
  .lk_start, .lk_addr_byte, .lk_rx_valid, .lk_rx_byte, .lk_stop,
  .lk_tx_req, .lk_rx_ack, .lk_tx_valid, .lk_tx_byte, .lk_busy,
  .csr_valid, .csr_write, .csr_index, .csr_be, .csr_wdata, .csr_ready,
  .csr_claimed, .csr_rdata, .read_unclaimed_flag, .write_unclaimed_flag);

`default_nettype wire

// File: smbcsr_top_tb.sv
// smbcsr_top_tb: random and corner-case register traffic over the link.
// assumes smbcsr_mst as link master; the register model lives here.
`default_nettype none

module smbcsr_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // clocks, design, register model
  // ---------------------------------------------------------------
  localparam logic [7:0] SLV = 8'hB0;
  logic        clock = 0, sys_rst = 1, lk_clk = 0;
  logic        lk_start, lk_rx_valid, lk_stop, lk_tx_req;
  logic [7:0]  lk_addr_byte, lk_rx_byte, lk_tx_byte;
  logic        lk_rx_ack, lk_tx_valid, lk_busy, csr_valid, csr_write;
  logic [13:0] csr_index;
  logic [3:0]  csr_be;
  logic [31:0] csr_wdata, csr_rdata = 0;
  logic        csr_ready = 0, csr_claimed = 0, go;
  logic        read_unclaimed_flag, write_unclaimed_flag;
  int          seed = 56, fails = 0, comparisons = 0, n_req = 0;
  int          wait_c = 40;
  bit          ck = 1;
  logic [50:0] last_req;
  logic [7:0]  fld [7];

  always #4 clock = ~clock;
  always #7.5 lk_clk = ~lk_clk;

  smbcsr_top u_dut (.clock, .sys_rst, .lk_clk, .lk_start, .lk_addr_byte,
    .lk_rx_valid, .lk_rx_byte, .lk_stop, .lk_tx_req, .lk_rx_ack,
    .lk_tx_valid, .lk_tx_byte, .lk_busy, .csr_valid, .csr_write,
    .csr_index, .csr_be, .csr_wdata, .csr_ready, .csr_claimed,
    .csr_rdata, .read_unclaimed_flag, .write_unclaimed_flag);
  smbcsr_mst u_mst (.lk_clk, .lk_rx_ack, .lk_tx_valid, .lk_tx_byte,
    .lk_start, .lk_addr_byte, .lk_rx_valid, .lk_rx_byte, .lk_stop,
    .lk_tx_req);

  function automatic logic [31:0] pat(input logic [13:0] i);
    return {2'h0, i, 2'h3, ~i};
  endfunction : pat

  // upper index bit set means nobody claims the word
  always @(negedge clock)
  begin
    go = csr_valid === 1'b1 && csr_ready === 1'b0 && wait_c == 0;
    csr_ready <= go;
    csr_claimed <= go ? ~csr_index[13] : 1'($random(seed));
    csr_rdata <= go ? pat(csr_index) : $random(seed);
    if (go)
    begin
      last_req <= {csr_write, csr_index, csr_be, csr_wdata};
      n_req <= n_req + 1;
      wait_c <= $random(seed) & 7;
    end
    else if (csr_valid === 1'b1 && wait_c > 0)
      wait_c <= wait_c - 1;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic complete_run;
    $display("checks %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  task automatic wait_idle;
    int k;
    repeat (3) @(negedge lk_clk);
    for (k = 0; k < 400 && lk_busy !== 1'b0; k++)
      @(negedge lk_clk);
    if (k == 400)
    begin
      fails++;
      complete_run();
    end
    @(negedge clock);
  endtask : wait_idle

  task automatic pb(input logic [7:0] b);
    logic a;
    u_mst.put_byte(b, a);
    if (ck)
      chk(a, 1'b1);
  endtask : pb

  // split mode walks word transactions, a lone last field goes as byte
  task automatic send(input int n, input bit split, input bit pec,
                      input logic [7:0] xc, input bit bad);
    int i;
    logic [1:0] sz;
    if (!split)
    begin
      u_mst.put_start(SLV);
      pb({pec, 7'h43} ^ xc);
      pb(n[7:0]);
      for (i = 0; i < n; i++)
        pb(fld[i]);
      if (pec)
        pb(u_mst.crc ^ {7'h0, bad});
      u_mst.put_stop();
    end
    else
      for (i = 0; i < n; i += 2)
      begin
        sz = (i + 1 < n) ? 2'h1 : 2'h0;
        u_mst.put_start(SLV);
        pb({1'b0, sz, 3'h0, (i == 0), (i + 2 >= n)});
        pb(fld[i]);
        if (i + 1 < n)
          pb(fld[i + 1]);
        u_mst.put_stop();
      end
  endtask : send

  initial
  begin
    logic [13:0] idx;
    logic [3:0]  ln;
    logic [31:0] d, p;
    logic [7:0]  ex [8];
    logic [8:0]  vb;
    logic        a, ew, er;
    int          it, j, k, n0;
    repeat (12) @(negedge clock);
    sys_rst = 0;
    er = 1'b0;
    repeat (6) @(negedge lk_clk);
    for (it = 0; it < 30; it++)
    begin
      idx = $random(seed);
      ln = (it == 1) ? 4'h0 : 4'($random(seed));
      d = $random(seed);
      // bit 6 of a write clears the read flag
      fld = '{{1'b0, it[3], 2'h0, ln}, idx[7:0], {2'h0, idx[13:8]},
              d[7:0], d[15:8], d[23:16], d[31:24]};
      send(7, it[0], it[1], 8'h00, 1'b0);
      if (it == 0)
      begin
        repeat (3) @(negedge lk_clk);
        chk(lk_busy, 1'b1);
        u_mst.put_byte(8'h55, a);
        chk(a, 1'b0);
        u_mst.get_byte(vb);
        chk(vb, 9'h1FF);
      end
      wait_idle();
      chk(last_req, {1'b1, idx, ln, d});
      chk(write_unclaimed_flag, idx[13]);
      chk(read_unclaimed_flag, it[3] ? 1'b0 : er);
      // bit 7 of a read clears the write flag
      ew = it[4] ? 1'b0 : idx[13];
      fld[0] = {it[4], 3'h1, ln};
      send(3, it[2], 1'b0, 8'h00, 1'b0);
      wait_idle();
      chk(last_req[50:32], {1'b0, idx, ln});
      chk(read_unclaimed_flag, idx[13]);
      chk(write_unclaimed_flag, ew);
      er = idx[13];
      p = pat(idx);
      ex = '{8'h07, {ew, idx[13], 2'h1, ln}, idx[7:0], {2'h0, idx[13:8]},
             p[7:0], p[15:8], p[23:16], p[31:24]};
      // odd rounds read back in word transfers, the last byte alone
      for (j = 0; j < (it[0] ? 7 : 1); j += 2)
      begin
        u_mst.put_start(SLV);
        pb(it[0] ? {2'h0, (j < 6), 3'h0, (j == 0), (j == 6)}
                 : 8'h43);
        u_mst.put_start(SLV | 8'h01);
        for (k = 0; k < (it[0] ? ((j < 6) ? 2 : 1) : 8); k++)
        begin
          u_mst.get_byte(vb);
          chk(vb, {1'b1, ex[k + j + it[0]]});
        end
        u_mst.put_stop();
      end
      wait_idle();
    end
    fld[0] = 8'h0F;
    ck = 0;
    // reserved size keeps the full field pointer: only size blocks it
    for (j = 0; j < 4; j++)
    begin
      n0 = n_req;
      send(7, 1'b0, j == 3, j == 0 ? 8'h04 : j == 1 ? 8'h22 :
           j == 2 ? 8'h18 : 8'h00, j == 3);
      wait_idle();
      chk(n_req, n0);
    end
    complete_run();
  end
endmodule : smbcsr_top_tb

`default_nettype wire
